// >>> rtl/occs_clock_synthesis.sv
// Notes on behaviour
// R01 - Bypass: master clock equals reference
// R02 - PLL: master equals reference times eight over postscaler
// R03 - Three-bit postscaler, ratios 1 to 32
// R04 - Integration unit halves master to 50 percent
// R05 - Reset selects relaxation oscillator, external optional
// R06 - Relaxation-derived outputs up to 32 MHz
// R07 - Relaxation oscillator feeds 8 MHz to PLL
// R08 - Fast peripheral clock at three times base; code gives only twice at PLL postscaler code 0
// R09 - Also oscillator, ADC and fast clocks
// R10 - Relaxation oscillator standby control
// R11 - Relaxation oscillator full power-down
// R12 - PLL power-down, bypass still usable
// R13 - Lost PLL reference triggers safety shutdown
// R14 - External reference arrives on port B bit six
// R15 - Pin use needs function select and bit
// R16 - Source or ratio changes make no runt pulses
`timescale 1ns/1ns
`default_nettype none
module occs_clock_synthesis
    import occs_pkg::*;
#(
    parameter int PHASES = 16                 // Sub-steps per reference cycle
) (
    input  wire logic               clk,              // 20 MHz system clock
    input  wire logic               rst,              // Sync, active high
    input  wire occs_pkg::occs_ctrl_s ctrl,           // Control bits
    input  wire logic               relax_osc_in,     // Relaxation osc level
    input  wire logic               port_b_bit_six_pin, // External ref pin
    output logic                    double_rate_system_clock, // Master enable
    output logic                    oscillator_clock_out,     // Ref clock
    output logic                    adc_clock,        // Master / 2 enable
    output logic                    fast_peripheral_clock, // 3x enable, 2x at postscaler code 0 in PLL mode
    output logic                    relax_standby_out, // To oscillator
    output logic                    relax_power_down_out, // To oscillator
    output logic                    pll_power_down_out, // To PLL
    output occs_pkg::occs_stat_s    status            // Status bits
);
    import occs_pkg::*;

    // Pin sync
    logic ext_s1_q, ext_s2_q, relax_s1_q, relax_s2_q;
    always_ff @(posedge clk) begin
        ext_s1_q   <= port_b_bit_six_pin;
        ext_s2_q   <= ext_s1_q;
        relax_s1_q <= relax_osc_in;
        relax_s2_q <= relax_s1_q;
    end

    // External path only when pin function and select bit agree
    wire ext_allowed = ctrl.pin_is_clock_in & ctrl.external_clock_select; // R15 R14
    wire relax_alive = ~ctrl.relax_power_down & ~ctrl.relax_standby;      // R10 R11

    // Reference selection applied only on a reference low phase
    logic ref_sel_q, ref_prev_q, ref_sel_d;
    wire  ref_raw  = ref_sel_q ? ext_s2_q : (relax_s2_q & relax_alive);
    wire  ref_rise = ref_raw & ~ref_prev_q;
    wire  sel_want = ext_allowed;                                      // R05
    assign ref_sel_d = (~ref_raw & ~ref_prev_q) ? sel_want : ref_sel_q; // R16

    // Loss-of-reference watchdog
    logic [7:0] loss_cnt_q;
    logic       lost_q;
    wire        loss_hit = (loss_cnt_q == OCCS_LOSS_CYCLES);
    wire [7:0]  loss_cnt_d = ref_rise ? 8'h00 :
                             (loss_hit ? loss_cnt_q : loss_cnt_q + 8'h01);

    // PLL model: eight output events per reference edge
    wire        pll_on = ctrl.pll_select & ~ctrl.pll_power_down & ~lost_q; // R12 R13
    logic [$clog2(PHASES)-1:0] ph_q;
    logic [3:0] pll_burst_q;
    wire        pll_tick = (pll_burst_q != 4'h0) && (ph_q[0] == 1'b0);
    // A tick due on the reload cycle is kept, so no edge is lost
    wire [3:0]  pll_burst_d = ref_rise ?
                              4'(OCCS_PLL_MULT) + pll_burst_q -
                              {3'h0, pll_tick} :                          // R02 R07
                              (pll_tick ? pll_burst_q - 4'h1 : pll_burst_q);

    // Postscaler, ratio 2^code, code clamped to 5
    logic [2:0] post_q;
    logic [4:0] post_cnt_q;
    wire  [2:0] post_want = (ctrl.postscaler > OCCS_POST_MAX_CODE) ?
                            OCCS_POST_MAX_CODE : ctrl.postscaler;        // R03
    wire  [4:0] post_mask = 5'((6'h01 << post_q) - 6'h01);
    wire        post_wrap = (post_cnt_q & post_mask) == post_mask;
    wire        post_tick = pll_tick & post_wrap;
    // New ratio takes effect only at a wrap, so no short period
    wire  [2:0] post_d = post_tick ? post_want : post_q;                // R16

    wire master_ev = pll_on ? post_tick : ref_rise;                     // R01 R02

    // ADC clock at half master, fast clock at three per master, two per master at postscaler code 0 in PLL mode
    logic adc_tgl_q;
    logic [1:0] fast_q;
    wire  [1:0] fast_d = master_ev ? 2'(OCCS_FAST_MULT) :
                         (fast_q != 2'h0 ? fast_q - 2'h1 : 2'h0);       // R08

    always_ff @(posedge clk) begin
        if (rst) begin
            ref_sel_q   <= OCCS_EXTSEL_RST;                              // R05
            ref_prev_q  <= 1'b0;
            loss_cnt_q  <= 8'h00;
            lost_q      <= 1'b0;
            ph_q        <= '0;
            pll_burst_q <= 4'h0;
            post_q      <= OCCS_POST_RST;
            post_cnt_q  <= 5'h00;
            adc_tgl_q   <= 1'b0;
            fast_q      <= 2'h0;
            double_rate_system_clock <= 1'b0;
            oscillator_clock_out     <= 1'b0;
            adc_clock                <= 1'b0;
            fast_peripheral_clock    <= 1'b0;
            relax_standby_out        <= 1'b0;
            relax_power_down_out     <= 1'b0;
            pll_power_down_out       <= 1'b0;
            status                   <= '0;
        end else begin
            ref_sel_q   <= ref_sel_d;
            ref_prev_q  <= ref_raw;
            loss_cnt_q  <= loss_cnt_d;
            // Sticky until PLL is powered down, then rearmed
            lost_q      <= (lost_q | (ctrl.pll_select & loss_hit)) &
                           ~ctrl.pll_power_down;                         // R13
            ph_q        <= ph_q + 1'b1;
            pll_burst_q <= pll_burst_d;
            post_q      <= post_d;
            // Restart at each wrap so a new ratio starts a full period
            post_cnt_q  <= post_tick ? 5'h00 :
                           (pll_tick ? post_cnt_q + 5'h01 : post_cnt_q); // R16
            adc_tgl_q   <= master_ev ? ~adc_tgl_q : adc_tgl_q;
            fast_q      <= fast_d;
            double_rate_system_clock <= master_ev;                      // R06
            oscillator_clock_out     <= ref_raw;                        // R09
            adc_clock                <= master_ev & adc_tgl_q;          // R09
            fast_peripheral_clock    <= (fast_q != 2'h0);               // R08
            relax_standby_out        <= ctrl.relax_standby;             // R10
            relax_power_down_out     <= ctrl.relax_power_down;          // R11
            pll_power_down_out       <= ctrl.pll_power_down;            // R12
            status.ref_lost          <= lost_q;
            status.pll_active        <= pll_on;
            status.ref_is_external   <= ref_sel_q;
            status.post_applied      <= post_q;
        end
    end
endmodule // occs_clock_synthesis
`default_nettype wire

// >>> rtl/occs_pkg.sv
package occs_pkg;

    // Reference choice and postscaler codes
    typedef enum logic [0:0] {
        OCCS_REF_RELAX = 1'b0,
        OCCS_REF_EXT   = 1'b1
    } occs_ref_e;

    localparam logic [2:0] OCCS_POST_MAX_CODE = 3'h5;   // Divide by 32
    localparam int         OCCS_PLL_MULT      = 8;
    localparam int         OCCS_FAST_MULT     = 3;

    // Relaxation oscillator model: nominal 8 MHz
    localparam int OCCS_RELAX_KHZ  = 8000;
    localparam int OCCS_MAX_OUT_KHZ = 32000;

    // Loss-of-reference window, in system clock cycles
    localparam logic [7:0] OCCS_LOSS_CYCLES = 8'h40;

    // Reset values
    localparam logic [2:0] OCCS_POST_RST   = 3'h0;
    localparam logic       OCCS_EXTSEL_RST = 1'b0;

    typedef struct packed {
        logic       external_clock_select;  // Oscillator control: ext ref
        logic       pll_select;             // Use PLL path
        logic [2:0] postscaler;             // Code 0..5 = div 1..32
        logic       relax_standby;
        logic       relax_power_down;
        logic       pll_power_down;
        logic       pin_is_clock_in;        // Pin function from SIU
    } occs_ctrl_s;

    typedef struct packed {
        logic       ref_lost;               // Sticky loss of reference
        logic       pll_active;             // PLL path drives master
        logic       ref_is_external;
        logic [2:0] post_applied;
    } occs_stat_s;

endpackage

// >>> tb/occs_chk_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module occs_chk
    import occs_pkg::*;
#(parameter int PHASES = 16) (
    input wire logic                 clk,                      // Clock
    input wire logic                 rst,                      // Reset
    input wire occs_pkg::occs_ctrl_s ctrl,                     // Controls
    input wire logic                 relax_osc_in,             // Osc
    input wire logic                 port_b_bit_six_pin,       // Pin
    input wire logic                 double_rate_system_clock, // Master
    input wire logic                 oscillator_clock_out,     // Ref
    input wire logic                 adc_clock,                // Adc
    input wire logic                 fast_peripheral_clock,    // Fast
    input wire logic                 relax_standby_out,        // Standby
    input wire logic                 relax_power_down_out,     // Off
    input wire logic                 pll_power_down_out,       // Pll off
    input wire occs_pkg::occs_stat_s status                    // Status
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_sb_follows: assert property (!$past(rst) |->
        relax_standby_out == $past(ctrl.relax_standby)) else $error("sb");
    a_pd_follows: assert property (!$past(rst) |->
        relax_power_down_out == $past(ctrl.relax_power_down)) else $error("pd");
    a_master_single: assert property (double_rate_system_clock |=>
        !double_rate_system_clock) else $error("runt");
    a_fast_three: assert property (double_rate_system_clock |->
        ##[0:1] fast_peripheral_clock [*3]) else $error("fast");
    a_adc_single: assert property (adc_clock |=> !adc_clock)
        else $error("adc");
    a_ext_granted: assert property ($rose(status.ref_is_external) |->
        $past(ctrl.external_clock_select && ctrl.pin_is_clock_in))
        else $error("ext");
    a_post_legal: assert property (status.post_applied <= 3'h5)
        else $error("post");
    a_lost_sticky: assert property (status.ref_lost &&
        !ctrl.pll_power_down |=> status.ref_lost && !status.pll_active)
        else $error("lost");
endmodule // occs_chk
bind occs_clock_synthesis occs_chk #(.PHASES(PHASES)) i_occs_chk (
    .clk(clk), .rst(rst), .ctrl(ctrl), .relax_osc_in(relax_osc_in),
    .port_b_bit_six_pin(port_b_bit_six_pin), .adc_clock(adc_clock),
    .double_rate_system_clock(double_rate_system_clock),
    .oscillator_clock_out(oscillator_clock_out), .status(status),
    .fast_peripheral_clock(fast_peripheral_clock),
    .relax_standby_out(relax_standby_out), .pll_power_down_out(pll_power_down_out),
    .relax_power_down_out(relax_power_down_out));
`default_nettype wire

// >>> tb/occs_siu_model.sv
`timescale 1ns/1ns
`default_nettype none
module occs_siu_model (
    input  wire logic clk,     // Clock
    input  wire logic rst,     // Reset
    input  wire logic master,  // Master pulse
    output var logic  sys_clk  // Halved clock
);
    // One toggle per master edge keeps both halves equal
    always_ff @(posedge clk) begin
        if (rst) sys_clk <= 1'b0;
        else if (master) sys_clk <= ~sys_clk;
    end
endmodule // occs_siu_model
`default_nettype wire

// >>> tb/occs_clock_synthesis_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module occs_clock_synthesis_tb_top;
    import occs_pkg::*;
    logic clk = 1'b0, rst = 1'b1, osc = 1'b0, pin = 1'b1;
    occs_ctrl_s ctrl = '0;
    occs_stat_s status;
    logic mst, adc, fst, sb, pd, ppd, sys;
    int num_errors = 0, total_checks = 0, cyc = 0, per, p, seed = 32'h71f3;
    occs_clock_synthesis #(.PHASES(16)) i_occs_clock_synthesis (.clk(clk),
        .rst(rst), .ctrl(ctrl), .relax_osc_in(osc), .port_b_bit_six_pin(pin),
        .double_rate_system_clock(mst), .oscillator_clock_out(), .status(status),
        .adc_clock(adc), .fast_peripheral_clock(fst), .relax_standby_out(sb),
        .relax_power_down_out(pd), .pll_power_down_out(ppd));
    occs_siu_model i_occs_siu_model (.clk(clk), .rst(rst), .master(mst),
        .sys_clk(sys));
    initial forever #25 clk = ~clk;
    always @(posedge clk) if (++cyc > 30000) begin
        num_errors++;
        results;
    end
    // Oscillator at the fastest period the PLL tracks
    initial forever begin
        repeat (8) @(posedge clk);
        #2 osc = ~osc;
    end
    initial begin
        per = 16 + 2 * ($random(seed) & 7);
        forever begin
            repeat (per / 2) @(posedge clk);
            #2 pin = ~pin;
        end
    end
    task step; @(posedge clk); #2; endtask
    task settle; repeat (300) step; endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s expected %0d seen %0d", nm, e, s);
        end
    endtask
    task gap(input int e);
        int n;
        logic s;
        n = 0;
        while (mst !== 1'b1 && n < 600) begin step; n++; end
        s = sys;
        step;
        n = 1;
        while (mst !== 1'b1 && n < 600) begin step; n++; end
        chk("gap", n, e);
        chk("half", sys !== s, 1);
    endtask
    task results;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (6) step;
        rst = 1'b0;
        step;
        chk("ext", status.ref_is_external, 0);
        settle;
        gap(16);
        ctrl.pll_select = 1'b1;
        for (p = 0; p < 8; p++) begin
            ctrl.postscaler = p[2:0];
            settle;
            gap(2 << (p > 5 ? 5 : p));
            chk("post", status.post_applied, p > 5 ? 5 : p);
        end
        ctrl.relax_standby = 1'b1;
        settle;
        chk("sb", sb, 1);
        chk("lost", {status.ref_lost, status.pll_active}, 2);
        ctrl = '{pll_select: 1, pll_power_down: 1, relax_power_down: 1,
                 default: 0};
        step;
        step;
        chk("off", {ppd, pd, status.ref_lost}, 6);
        ctrl.relax_power_down = 1'b0;
        settle;
        gap(16);
        ctrl.external_clock_select = 1'b1;
        settle;
        chk("nopin", status.ref_is_external, 0);
        ctrl.pin_is_clock_in = 1'b1;
        settle;
        chk("pin", status.ref_is_external, 1);
        gap(per);
        results;
    end
endmodule // occs_clock_synthesis_tb_top
`default_nettype wire
